// File: rtl/fault_capture_pkg.sv
// constants for the six-channel fault capture and flag logic
//
// Overview of operation
// - one active-low open-drain fault flag, OR of all unmasked channels
// - flag low when unmasked channel faulted and both enables and select high
// - flag released and disabled while enable one or select is low
// - shorted load checked when on; ground short or open load when off
// - all diagnostics disabled while either enable is low
// - comparisons run continuously; results latched only at timer expiry
// - all blanking timers start when both enables become high
// - channel blanking timer starts on any change of its commanded state
// - abnormal comparison at blanking end loads code into fault latch
// - comparison change starts filter timer; abnormal at expiry is latched
// - fault-to-good comparison change does not start the filter timer
// - fault latch updates held off while blanking or filter timer runs
// - captured code held, later results ignored until a valid frame
// - select falling copies latched codes to shift register, flag released
// - select rising re-arms latches only after a valid frame
// - after re-arm the flag and latch recapture a fault still present
// - received word is not written when the frame was invalid
// - frames carry 16 bits and return all two-bit fault codes
// - enable one high-low-high clears and re-arms latches and flag
// - shorted load in auto-retry turns gate off, flags, starts retry timer
// - retry end turns gate on again; fault at blanking end turns it off
// - one shared refresh timer, 10 ms or 40 ms per group of three
package fault_capture_pkg;
  localparam int NUM_CH     = 6;
  localparam int CODE_W     = 2;
  localparam int FRAME_BITS = 16;
  localparam int GROUP_SIZE = 3;
  localparam int CNT_W      = 5;
  localparam int TMR_W      = 12;
  localparam int REF_W      = 20;

  localparam logic [CODE_W-1:0] CODE_NONE   = 2'h0;
  localparam logic [CODE_W-1:0] CODE_OPEN   = 2'h1;
  localparam logic [CODE_W-1:0] CODE_GROUND = 2'h2;
  localparam logic [CODE_W-1:0] CODE_SHORT  = 2'h3;

  localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;
  localparam int CODE_BITS = NUM_CH * CODE_W;

  localparam int CLK_HZ       = 25_000_000;
  localparam int BLANK_ON_US  = 20;
  localparam int BLANK_OFF_US = 40;
  localparam int FILTER_US    = 10;
  localparam logic [TMR_W-1:0] BLANK_ON_CYC  =
    TMR_W'(CLK_HZ / 1_000_000 * BLANK_ON_US);
  localparam logic [TMR_W-1:0] BLANK_OFF_CYC =
    TMR_W'(CLK_HZ / 1_000_000 * BLANK_OFF_US);
  localparam logic [TMR_W-1:0] FILTER_CYC    =
    TMR_W'(CLK_HZ / 1_000_000 * FILTER_US);
  localparam logic [TMR_W-1:0] TMR_LAST      = 12'h001;

  localparam int REFRESH_SHORT_MS = 10;
  localparam int REFRESH_LONG_MS  = 40;
  localparam int REFRESH_SHORT_DEF = CLK_HZ / 1000 * REFRESH_SHORT_MS;
  localparam logic [1:0] REFRESH_LAST_QUARTER =
    2'(REFRESH_LONG_MS / REFRESH_SHORT_MS - 1);
endpackage

// File: rtl/chan_if.sv
// per-channel link between the capture top and one channel engine
`timescale 1ns/100ps
`default_nettype none
interface chan_if;
  import fault_capture_pkg::*;
  logic              enabled;
  logic              blank_all;
  logic              clear;
  logic              rearm;
  logic              cmd;
  logic              auto_retry;
  logic              retry_tick;
  logic              cmp_short;
  logic              cmp_open;
  logic              cmp_ground;
  logic [CODE_W-1:0] code;
  logic              gate_on;
  logic              retry_wait;

  modport top (
    output enabled, blank_all, clear, rearm, cmd, auto_retry, retry_tick,
    output cmp_short, cmp_open, cmp_ground,
    input  code, gate_on, retry_wait
  );
  modport chan (
    input  enabled, blank_all, clear, rearm, cmd, auto_retry, retry_tick,
    input  cmp_short, cmp_open, cmp_ground,
    output code, gate_on, retry_wait
  );
endinterface
`default_nettype wire

// File: rtl/fault_channel.sv
// one channel: blanking and filter timing, fault latch, retry gating
`timescale 1ns/100ps
`default_nettype none
module fault_channel (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link to top
  chan_if.chan     ch
);
  import fault_capture_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0]  cnt;
    logic              running;
    logic [CODE_W-1:0] result_d;
    logic [CODE_W-1:0] detected;
    logic [CODE_W-1:0] latch;
    logic              off;
    logic              cmd_d;
    logic              gate_d;
  } chan_state_s;

  chan_state_s       st_reg;
  chan_state_s       st_next;
  logic              gate_now;
  logic [CODE_W-1:0] result;
  logic              expire;

  assign gate_now = ch.enabled & ch.cmd & ~st_reg.off;

  always_comb begin
    // references chosen by gate state
    if (gate_now) begin
      result = ch.cmp_short ? CODE_SHORT : CODE_NONE;
    end else if (ch.cmp_ground) begin
      result = CODE_GROUND;
    end else begin
      result = ch.cmp_open ? CODE_OPEN : CODE_NONE;
    end
  end

  assign expire = st_reg.running && (st_reg.cnt == TMR_LAST);

  always_comb begin
    st_next          = st_reg;
    st_next.result_d = result;
    st_next.cmd_d    = ch.cmd;
    st_next.gate_d   = gate_now;
    if (!ch.enabled) begin
      st_next.running  = 1'b0;
      st_next.detected = CODE_NONE;
      st_next.off      = 1'b0;
    end else begin
      if (st_reg.running) begin
        st_next.cnt = st_reg.cnt - TMR_LAST;
      end
      if (expire) begin
        st_next.running  = 1'b0;
        st_next.detected = result;
        if (result == CODE_SHORT) begin
          st_next.off = 1'b1;
        end
      end else if (result == CODE_NONE) begin
        st_next.detected = CODE_NONE;
      end
      if (result != st_reg.result_d && result != CODE_NONE) begin
        st_next.running = 1'b1;
        st_next.cnt     = FILTER_CYC;
      end
      if (ch.blank_all || ch.cmd != st_reg.cmd_d ||
          gate_now != st_reg.gate_d) begin
        st_next.running = 1'b1;
        st_next.cnt     = gate_now ? BLANK_ON_CYC : BLANK_OFF_CYC;
      end
      if (st_reg.off) begin
        if (!ch.cmd) begin
          st_next.off = 1'b0;
        end else if (ch.auto_retry && ch.retry_tick) begin
          st_next.off = 1'b0;
        end
      end
    end
    // latch: capture, hold, re-arm
    if (ch.clear) begin
      st_next.latch = CODE_NONE;
    end else if (!st_reg.running && !expire) begin
      if (ch.rearm) begin
        st_next.latch = st_reg.detected;
      end else if (st_reg.latch == CODE_NONE) begin
        st_next.latch = st_reg.detected;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ch.code       = st_reg.latch;
  assign ch.gate_on    = gate_now;
  assign ch.retry_wait = st_reg.off & ch.auto_retry;
endmodule
`default_nettype wire

// File: rtl/fault_capture_flag_logic.sv
// fault capture, serial fault readback, fault flag and retry timing
`timescale 1ns/100ps
`default_nettype none
module fault_capture_flag_logic #(
  parameter int REFRESH_SHORT_CYC = fault_capture_pkg::REFRESH_SHORT_DEF
) (
  // clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   resetn,
  // enable and command pins
  input  wire logic                                   master_enable_one,
  input  wire logic                                   master_enable_two,
  input  wire logic [fault_capture_pkg::NUM_CH-1:0]   parallel_cmd_input,
  // serial link pins
  input  wire logic                                   select_n,
  input  wire logic                                   sclk,
  input  wire logic                                   mosi,
  output var  logic                                   miso,
  // comparator results per channel
  input  wire logic [fault_capture_pkg::NUM_CH-1:0]   cmp_short,
  input  wire logic [fault_capture_pkg::NUM_CH-1:0]   cmp_open,
  input  wire logic [fault_capture_pkg::NUM_CH-1:0]   cmp_ground,
  // configuration
  input  wire logic [fault_capture_pkg::NUM_CH-1:0]   serial_gate_bit,
  input  wire logic [fault_capture_pkg::NUM_CH-1:0]   flag_mask,
  input  wire logic [fault_capture_pkg::NUM_CH-1:0]   auto_retry_mode,
  input  wire logic [1:0]                             refresh_long_sel,
  // received frame
  output var  logic [fault_capture_pkg::FRAME_BITS-1:0] rx_word,
  output var  logic                                   rx_write,
  // drive and flag outputs
  output var  logic [fault_capture_pkg::NUM_CH-1:0]   gate_drive_out,
  output var  logic [fault_capture_pkg::CODE_BITS-1:0] fault_codes,
  output var  logic                                   fault_flag_n_o,
  output var  logic                                   fault_flag_n_oe
);
  import fault_capture_pkg::*;

  localparam int SYNC_W = 5 + 4 * NUM_CH;

  typedef struct packed {
    logic [SYNC_W-1:0]     sync1;
    logic [SYNC_W-1:0]     sync2;
    logic                  both_d;
    logic                  sel_d;
    logic                  sclk_d;
    logic [CNT_W-1:0]      bit_cnt;
    logic [FRAME_BITS-1:0] shift;
    logic [FRAME_BITS-1:0] rx;
    logic                  rx_write;
    logic                  rearm;
    logic [REF_W-1:0]      ref_cnt;
    logic [1:0]            quarter;
    logic [NUM_CH-1:0]     gate;
    logic [CODE_BITS-1:0]  codes;
    logic                  flag_oe;
  } top_state_s;

  top_state_s st_reg;
  top_state_s st_next;

  logic              e1;
  logic              e2;
  logic              sel;
  logic              sclk_s;
  logic              mosi_s;
  logic [NUM_CH-1:0] cmd_s;
  logic [NUM_CH-1:0] sh_s;
  logic [NUM_CH-1:0] op_s;
  logic [NUM_CH-1:0] gr_s;
  logic              both;
  logic              tick_short;
  logic              tick_long;
  logic [NUM_CH-1:0] gate_w;
  logic [NUM_CH-1:0] wait_w;
  logic [CODE_BITS-1:0] code_w;
  logic [NUM_CH-1:0] flt_w;

  // synchronised pin levels, second stage only
  assign {e1, e2, sel, sclk_s, mosi_s, cmd_s, sh_s, op_s, gr_s} =
    st_reg.sync2;
  assign both = e1 & e2;

  // shared refresh taps
  assign tick_short = (st_reg.ref_cnt == REF_W'(REFRESH_SHORT_CYC - 1));
  assign tick_long  = tick_short && (st_reg.quarter == REFRESH_LAST_QUARTER);

  chan_if ch [NUM_CH] ();

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign ch[gi].enabled    = both;
      assign ch[gi].blank_all  = both & ~st_reg.both_d;
      assign ch[gi].clear      = ~e1;
      assign ch[gi].rearm      = st_reg.rearm;
      assign ch[gi].cmd        = cmd_s[gi] | serial_gate_bit[gi];
      assign ch[gi].auto_retry = auto_retry_mode[gi];
      assign ch[gi].retry_tick = refresh_long_sel[gi / GROUP_SIZE] ?
                                 tick_long : tick_short;
      assign ch[gi].cmp_short  = sh_s[gi];
      assign ch[gi].cmp_open   = op_s[gi];
      assign ch[gi].cmp_ground = gr_s[gi];
      assign gate_w[gi]        = ch[gi].gate_on;
      assign wait_w[gi]        = ch[gi].retry_wait;
      assign code_w[gi*CODE_W +: CODE_W] = ch[gi].code;
      assign flt_w[gi] = (ch[gi].code != CODE_NONE) & ~flag_mask[gi];

      fault_channel u_chan (
        .clk    (clk),
        .resetn (resetn),
        .ch     (ch[gi])
      );
    end
  endgenerate

  always_comb begin
    st_next          = st_reg;
    st_next.sync1    = {master_enable_one, master_enable_two, select_n,
                        sclk, mosi, parallel_cmd_input, cmp_short,
                        cmp_open, cmp_ground};
    st_next.sync2    = st_reg.sync1;
    st_next.both_d   = both;
    st_next.sel_d    = sel;
    st_next.sclk_d   = sclk_s;
    st_next.rx_write = 1'b0;
    st_next.rearm    = 1'b0;
    st_next.gate     = gate_w;
    st_next.codes    = code_w;

    // serial frame
    if (!sel && st_reg.sel_d) begin
      st_next.shift   = {{(FRAME_BITS - CODE_BITS){1'b0}}, code_w};
      st_next.bit_cnt = '0;
    end else if (!sel) begin
      if (sclk_s && !st_reg.sclk_d) begin
        st_next.rx = {st_reg.rx[FRAME_BITS-2:0], mosi_s};
        if (st_reg.bit_cnt != '1) begin
          st_next.bit_cnt = st_reg.bit_cnt + CNT_W'(1);
        end
      end else if (!sclk_s && st_reg.sclk_d) begin
        st_next.shift = {st_reg.shift[FRAME_BITS-2:0], 1'b0};
      end
    end else if (!st_reg.sel_d && st_reg.bit_cnt == FRAME_LEN) begin
      st_next.rx_write = 1'b1;
      st_next.rearm    = 1'b1;
    end

    // shared refresh timer runs while any channel waits
    if (|wait_w) begin
      if (tick_short) begin
        st_next.ref_cnt = '0;
        st_next.quarter = st_reg.quarter + 2'(1);
      end else begin
        st_next.ref_cnt = st_reg.ref_cnt + REF_W'(1);
      end
    end else begin
      st_next.ref_cnt = '0;
      st_next.quarter = '0;
    end

    // open-drain flag
    st_next.flag_oe = (|flt_w) & e1 & e2 & sel;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign miso            = st_reg.shift[FRAME_BITS-1];
  assign rx_word         = st_reg.rx;
  assign rx_write        = st_reg.rx_write;
  assign gate_drive_out  = st_reg.gate;
  assign fault_codes     = st_reg.codes;
  assign fault_flag_n_o  = 1'b0;
  assign fault_flag_n_oe = st_reg.flag_oe;
endmodule
`default_nettype wire

// File: bench/fault_capture_flag_logic_properties.sv
// concurrent checks on the fault capture top ports
`timescale 1ns/100ps
`default_nettype none
module fault_capture_props #(
  parameter int REFRESH_SHORT_CYC = fault_capture_pkg::REFRESH_SHORT_DEF
) (
  // clock and reset
  input wire logic                                    clk,
  input wire logic                                    resetn,
  // inputs watched
  input wire logic                                    master_enable_one,
  input wire logic                                    master_enable_two,
  input wire logic                                    select_n,
  input wire logic [fault_capture_pkg::NUM_CH-1:0]    flag_mask,
  input wire logic [fault_capture_pkg::NUM_CH-1:0]    auto_retry_mode,
  // outputs watched
  input wire logic                                    rx_write,
  input wire logic [fault_capture_pkg::NUM_CH-1:0]    gate_drive_out,
  input wire logic [fault_capture_pkg::CODE_BITS-1:0] fault_codes,
  input wire logic                                    fault_flag_n_o,
  input wire logic                                    fault_flag_n_oe
);
  import fault_capture_pkg::*;
  logic [NUM_CH-1:0] live;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      live[i] = (fault_codes[2*i+:2] != CODE_NONE) && !flag_mask[i];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_flag_od_low: assert property (fault_flag_n_o == 1'b0)
    else $error("flag data not low");
  a_flag_has_cause: assert property (fault_flag_n_oe |->
    (live | $past(live) | $past(live, 2)) != '0)
    else $error("flag set without unmasked fault");
  a_flag_off_ena: assert property (
    !master_enable_one [*6] |-> !fault_flag_n_oe)
    else $error("flag driven with enable one low");
  a_flag_off_sel: assert property (
    !select_n [*6] |-> !fault_flag_n_oe)
    else $error("flag driven with select low");
  a_codes_clr_ena: assert property (
    !master_enable_one [*6] |-> fault_codes == '0)
    else $error("codes kept with enable one low");
  a_gate_off_ena: assert property (
    !(master_enable_one && master_enable_two) [*6]
    |-> gate_drive_out == '0)
    else $error("gate on with an enable low");
  a_write_one_pulse: assert property (rx_write |=> !rx_write)
    else $error("write strobe longer than one cycle");
  a_write_sel_high: assert property (
    rx_write |-> select_n && $past(select_n))
    else $error("write strobe inside a frame");
  a_short_gate_off: assert property (
    $rose(fault_codes[5:4] == CODE_SHORT) && auto_retry_mode[2]
    |-> ##[0:2] !gate_drive_out[2])
    else $error("gate left on after shorted load");
endmodule
bind fault_capture_flag_logic fault_capture_props #(
  .REFRESH_SHORT_CYC(REFRESH_SHORT_CYC)
) i_fault_capture_props (
  .clk(clk), .resetn(resetn), .master_enable_one(master_enable_one),
  .master_enable_two(master_enable_two), .select_n(select_n),
  .flag_mask(flag_mask), .auto_retry_mode(auto_retry_mode),
  .rx_write(rx_write), .gate_drive_out(gate_drive_out),
  .fault_codes(fault_codes), .fault_flag_n_o(fault_flag_n_o),
  .fault_flag_n_oe(fault_flag_n_oe)
);
`default_nettype wire

// File: bench/spi_host.sv
// host controller model, serial master in mode 0
`timescale 1ns/100ps
`default_nettype none
module spi_host (
  // clock for pacing
  input  wire logic clk,
  // serial link
  input  wire logic miso,
  output logic      select_n,
  output logic      sclk,
  output logic      mosi
);
  initial begin
    select_n = 1'b1;
    sclk     = 1'b0;
    mosi     = 1'b0;
  end
  task automatic xfer(input int nb, input logic [15:0] tx,
                      output logic [15:0] rx);
    rx = '0;
    @(negedge clk);
    select_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = nb - 1; i >= 0; i--) begin
      mosi = tx[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      rx = {rx[14:0], miso};
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    select_n = 1'b1;
    mosi = ~mosi;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// testbench for the fault capture and flag logic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fault_capture_pkg::*;
  logic                 clk, resetn, en1, en2, sel_n, sclk, mosi;
  logic                 miso, rxw, oe, od;
  logic [NUM_CH-1:0]    cmd, cs, co, cg, msk, sg, arm, gate;
  logic [1:0]           rls;
  logic [CODE_BITS-1:0] codes;
  logic [15:0]          rxd, got, last_wr;
  int                   bad_count = 0;
  int                   n_tests = 0;
  int                   wr_cnt = 0;
  fault_capture_flag_logic #(.REFRESH_SHORT_CYC(50))
    i_fault_capture_flag_logic (
    .clk(clk), .resetn(resetn), .master_enable_one(en1),
    .master_enable_two(en2), .parallel_cmd_input(cmd),
    .select_n(sel_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .cmp_short(cs), .cmp_open(co), .cmp_ground(cg),
    .serial_gate_bit(sg), .flag_mask(msk), .auto_retry_mode(arm),
    .refresh_long_sel(rls), .rx_word(rxd), .rx_write(rxw),
    .gate_drive_out(gate), .fault_codes(codes),
    .fault_flag_n_o(od), .fault_flag_n_oe(oe));
  spi_host i_spi_host (.clk(clk), .miso(miso), .select_n(sel_n),
    .sclk(sclk), .mosi(mosi));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rxw === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      last_wr <= rxd;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, e, input string m);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_gate(input logic v);
    int k;
    k = 0;
    while (gate[2] !== v && k < 1200) begin
      cyc(1);
      k++;
    end
    chk(16'(gate[2]), 16'(v), "retry gate");
  endtask
  initial begin
    #1_000_000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    resetn = 1'b0; en1 = 1'b0; en2 = 1'b0; cmd = '0; cs = '0;
    co = 6'h01; cg = '0; msk = '0; sg = '0; arm = '1; rls = 2'h0;
    cyc(8);
    resetn = 1'b1;
    cyc(1);
    chk(16'(gate), 16'h0000, "reset gate");
    chk(16'({codes, oe}), 16'h0000, "reset outputs");
    cyc(4);
    en1 = 1'b1;
    en2 = 1'b1;
    cyc(1100);
    chk(16'(codes), 16'(CODE_OPEN), "open load");
    chk(16'(oe), 16'h0001, "flag set");
    msk = 6'h01;
    cyc(4);
    chk(16'(oe), 16'h0000, "flag masked");
    msk = '0;
    co = '0;
    cyc(300);
    chk(16'({codes, oe}), 16'({CODE_OPEN, 1'b1}), "held");
    i_spi_host.xfer(15, 16'h1234, got);
    chk(16'(wr_cnt), 16'h0000, "bad frame write");
    chk(16'(codes), 16'(CODE_OPEN), "bad frame kept");
    i_spi_host.xfer(16, 16'ha5c3, got);
    chk(got, 16'(CODE_OPEN), "readback");
    chk(16'(wr_cnt), 16'h0001, "one write");
    chk(last_wr, 16'ha5c3, "rx word");
    chk(16'({codes, oe}), 16'h0000, "re-armed");
    cg = 6'h02;
    co = 6'h02;
    cyc(300);
    chk(16'(codes), 16'({CODE_GROUND, 2'h0}), "ground");
    i_spi_host.xfer(16, 16'h0f0f, got);
    chk(got, 16'({CODE_GROUND, 2'h0}), "ground read");
    chk(16'({codes, oe}), 16'({CODE_GROUND, 3'h1}), "recapture");
    en1 = 1'b0;
    cyc(8);
    chk(16'({codes, oe}), 16'h0000, "enable one low");
    cg = '0;
    co = '0;
    en1 = 1'b1;
    cyc(1100);
    chk(16'({codes, oe}), 16'h0000, "re-armed idle");
    cs = 6'h04;
    cmd = 6'h04;
    rls = 2'h1;
    cyc(8);
    chk(16'(gate), 16'h0004, "gate on");
    cyc(520);
    chk(16'({codes, oe}), 16'({CODE_SHORT, 5'h01}), "short");
    chk(16'(gate), 16'h0000, "gate off");
    cyc(100);
    chk(16'(gate), 16'h0000, "long refresh");
    wait_gate(1'b1);
    wait_gate(1'b0);
    cmd = '0;
    cs = '0;
    cyc(20);
    arm = 6'h37;
    cs = 6'h08;
    cyc(4);
    sg = 6'h08;
    cyc(4);
    chk(16'(gate), 16'h0008, "serial gate");
    cyc(600);
    chk(16'(codes[7:6]), 16'(CODE_SHORT), "latch-off code");
    chk(16'(gate), 16'h0000, "latch-off gate");
    cyc(300);
    chk(16'(gate), 16'h0000, "latch-off held");
    sg = '0;
    cs = '0;
    cyc(20);
    report_and_stop();
  end
endmodule
`default_nettype wire
